// ===== rtl/pin_reuse_gpio.sv
// pin reuse general i/o: enable, value and input registers for eight pins
// Summary of operation
// - enable bits 7..0 map signal in, clock out, selects b/a, test pins.
// - clock pin enable set turns clock function off, pin becomes i/o.
// - boundary scan active makes enable bits 3..0 have no effect.
// - output value bits give the level driven on each enabled pin.
// - input register returns the level seen at each pin input.
// - clock source select zero leaves the clock pin undriven for i/o.
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none

module pin_reuse_gpio (
	// clock and reset
	input  wire logic                                 clk_in,
	input  wire logic                                 nrst_in,
	// register port
	input  wire pin_reuse_gpio_pkg::reg_req_t         req_in,
	output logic [pin_reuse_gpio_pkg::DATA_W-1:0]     rdata_out,
	// configuration from elsewhere in the device
	input  wire logic                                 scan_active_in,
	input  wire logic [pin_reuse_gpio_pkg::SEL_W-1:0] clock_pin_source_select_in,
	input  wire logic                                 clock_source_level_in,
	// dedicated functions of the pins
	input  wire logic [pin_reuse_gpio_pkg::PIN_N-1:0] func_drive_in,
	input  wire logic [pin_reuse_gpio_pkg::PIN_N-1:0] func_level_in,
	output logic [pin_reuse_gpio_pkg::PIN_N-1:0]      func_seen_out,
	// pads
	input  wire logic [pin_reuse_gpio_pkg::PIN_N-1:0] pin_in,
	output logic [pin_reuse_gpio_pkg::PIN_N-1:0]      pin_out,
	output logic [pin_reuse_gpio_pkg::PIN_N-1:0]      pin_oe_n_out
);
	import pin_reuse_gpio_pkg::*;

	// ------------------------------------------------------------
	// storage
	// ------------------------------------------------------------
	logic [PIN_N-1:0]  enable_ff;
	logic [PIN_N-1:0]  value_ff;
	logic [PIN_N-1:0]  seen_ff;
	logic [DATA_W-1:0] rdata_ff;
	logic [PIN_N-1:0]  pin_ff;
	logic [PIN_N-1:0]  pin_oe_n_ff;

	logic [PIN_N-1:0]  eff_enable;
	logic [PIN_N-1:0]  nxt_pin;
	logic [PIN_N-1:0]  nxt_pin_oe_n;
	logic [DATA_W-1:0] nxt_rdata;

	logic wr_enable;
	logic wr_value;

	assign wr_enable = req_in.wr && (req_in.addr == PIN_OUTPUT_ENABLE_OFS);
	assign wr_value  = req_in.wr && (req_in.addr == PIN_OUTPUT_VALUE_OFS);

	// ------------------------------------------------------------
	// register writes
	// ------------------------------------------------------------
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			enable_ff <= PIN_OUTPUT_ENABLE_RST;
		end else if (wr_enable) begin
			enable_ff <= req_in.wdata;
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			value_ff <= PIN_OUTPUT_VALUE_RST;
		end else if (wr_value) begin
			value_ff <= req_in.wdata;
		end
	end

	// ------------------------------------------------------------
	// input sampling
	// ------------------------------------------------------------
	// pads are taken as synchronous; one flop keeps the read stable
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			seen_ff <= PIN_INPUT_VALUE_RST;
		end else begin
			seen_ff <= pin_in;
		end
	end

	// dedicated functions always see the pad, whoever drives it
	assign func_seen_out = pin_in;

	// ------------------------------------------------------------
	// read path
	// ------------------------------------------------------------
	always_comb begin
		nxt_rdata = UNMAPPED_READ_VALUE;
		if (req_in.rd) begin
			unique case (req_in.addr)
				PIN_OUTPUT_ENABLE_OFS: nxt_rdata = enable_ff;
				PIN_OUTPUT_VALUE_OFS:  nxt_rdata = value_ff;
				PIN_INPUT_VALUE_OFS:   nxt_rdata = seen_ff;
				default:               nxt_rdata = UNMAPPED_READ_VALUE;
			endcase
		end
	end

	// read data stand for the single cycle after the strobe
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rdata_ff <= READ_DATA_RST;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	assign rdata_out = rdata_ff;

	// ------------------------------------------------------------
	// pin multiplexing
	// ------------------------------------------------------------
	// test-port enables are masked while boundary scan owns the pins
	assign eff_enable = scan_active_in ?
		(enable_ff & ~TEST_PORT_MASK) : enable_ff;

	always_comb begin
		nxt_pin      = func_level_in;
		nxt_pin_oe_n = ~func_drive_in;
		// clock pin: the source select decides its dedicated drive
		if (clock_pin_source_select_in == CLOCK_SEL_IO) begin
			nxt_pin[CLOCK_OUTPUT_PIN_BIT]      = 1'b0;
			nxt_pin_oe_n[CLOCK_OUTPUT_PIN_BIT] = 1'b1;
		end else begin
			nxt_pin[CLOCK_OUTPUT_PIN_BIT]      = clock_source_level_in;
			nxt_pin_oe_n[CLOCK_OUTPUT_PIN_BIT] = 1'b0;
		end
		for (int i = 0; i < PIN_N; i++) begin
			if (eff_enable[i]) begin
				// general i/o wins over any dedicated use, clock included
				nxt_pin[i]      = value_ff[i];
				nxt_pin_oe_n[i] = 1'b0;
			end
		end
	end

	// registered pads: one cycle of latency on a forwarded clock,
	// traded for glitch-free pad drive
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			pin_ff      <= '0;
			pin_oe_n_ff <= '1;
		end else begin
			pin_ff      <= nxt_pin;
			pin_oe_n_ff <= nxt_pin_oe_n;
		end
	end

	assign pin_out      = pin_ff;
	assign pin_oe_n_out = pin_oe_n_ff;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	// the releasing edge still finds the flops in reset, so checks
	// start one edge after the reset pin rises
	logic checks_armed_ff;

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			checks_armed_ff <= 1'b0;
		end else begin
			checks_armed_ff <= 1'b1;
		end
	end

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!nrst_in || !checks_armed_ff);

	logic rd_input;
	logic rd_mapped;
	assign rd_input  = req_in.rd && (req_in.addr == PIN_INPUT_VALUE_OFS);
	assign rd_mapped = (req_in.addr == PIN_OUTPUT_ENABLE_OFS) ||
		(req_in.addr == PIN_OUTPUT_VALUE_OFS) ||
		(req_in.addr == PIN_INPUT_VALUE_OFS);

	signal_pin_drive_a: assert property (
		enable_ff[SIGNAL_INPUT_PIN_BIT] |=>
		!pin_oe_n_out[SIGNAL_INPUT_PIN_BIT] &&
		pin_out[SIGNAL_INPUT_PIN_BIT] ==
		$past(value_ff[SIGNAL_INPUT_PIN_BIT]))
		else $error("enabled signal pin not driven from value");

	enable_write_a: assert property (
		(wr_enable && req_in.wdata[INTERFACE_SELECT_PIN_B_BIT]) |=>
		##1 (!pin_oe_n_out[INTERFACE_SELECT_PIN_B_BIT] ||
		!enable_ff[INTERFACE_SELECT_PIN_B_BIT]))
		else $error("written enable did not reach select pin");

	clock_takeover_a: assert property (
		enable_ff[CLOCK_OUTPUT_PIN_BIT] |=>
		!pin_oe_n_out[CLOCK_OUTPUT_PIN_BIT] &&
		pin_out[CLOCK_OUTPUT_PIN_BIT] ==
		$past(value_ff[CLOCK_OUTPUT_PIN_BIT]))
		else $error("clock pin not taken over as i/o");

	scan_keeps_port_a: assert property (
		scan_active_in |=>
		pin_oe_n_out[TEST_CLOCK_PIN_BIT:TEST_DATA_OUT_PIN_BIT] ==
		$past(~func_drive_in[TEST_CLOCK_PIN_BIT:TEST_DATA_OUT_PIN_BIT]))
		else $error("test port enable honoured under scan");

	value_reaches_pad_a: assert property (
		(wr_value ##1 (enable_ff == '1 && !scan_active_in)) |=>
		pin_out == $past(req_in.wdata, 2))
		else $error("written value not on the pads");

	input_read_a: assert property (
		rd_input |=> rdata_out == $past(pin_in, 2))
		else $error("input read does not match pad level");

	clock_idle_a: assert property (
		(!enable_ff[CLOCK_OUTPUT_PIN_BIT] &&
		clock_pin_source_select_in == CLOCK_SEL_IO) |=>
		pin_oe_n_out[CLOCK_OUTPUT_PIN_BIT])
		else $error("clock pin driven with source select zero");

	clock_source_a: assert property (
		(!enable_ff[CLOCK_OUTPUT_PIN_BIT] &&
		clock_pin_source_select_in != CLOCK_SEL_IO) |=>
		!pin_oe_n_out[CLOCK_OUTPUT_PIN_BIT] &&
		pin_out[CLOCK_OUTPUT_PIN_BIT] == $past(clock_source_level_in))
		else $error("clock pin not showing its source");

	dedicated_keep_a: assert property (
		!enable_ff[INTERFACE_SELECT_PIN_A_BIT] |=>
		pin_oe_n_out[INTERFACE_SELECT_PIN_A_BIT] ==
		!$past(func_drive_in[INTERFACE_SELECT_PIN_A_BIT]) &&
		pin_out[INTERFACE_SELECT_PIN_A_BIT] ==
		$past(func_level_in[INTERFACE_SELECT_PIN_A_BIT]))
		else $error("disabled pin left its dedicated function");

	unmapped_read_a: assert property (
		(req_in.rd && !rd_mapped) |=> rdata_out == UNMAPPED_READ_VALUE)
		else $error("unmapped read returned nonzero");

	idle_read_a: assert property (
		!req_in.rd |=> rdata_out == READ_DATA_RST)
		else $error("read data not cleared after the read cycle");

	select_a_drive_a: assert property (
		enable_ff[INTERFACE_SELECT_PIN_A_BIT] |=>
		!pin_oe_n_out[INTERFACE_SELECT_PIN_A_BIT] &&
		pin_out[INTERFACE_SELECT_PIN_A_BIT] ==
		$past(value_ff[INTERFACE_SELECT_PIN_A_BIT]))
		else $error("enabled select a pin not driven from value");

	select_b_drive_a: assert property (
		enable_ff[INTERFACE_SELECT_PIN_B_BIT] |=>
		!pin_oe_n_out[INTERFACE_SELECT_PIN_B_BIT] &&
		pin_out[INTERFACE_SELECT_PIN_B_BIT] ==
		$past(value_ff[INTERFACE_SELECT_PIN_B_BIT]))
		else $error("enabled select b pin not driven from value");

	test_clock_drive_a: assert property (
		(enable_ff[TEST_CLOCK_PIN_BIT] && !scan_active_in) |=>
		!pin_oe_n_out[TEST_CLOCK_PIN_BIT] &&
		pin_out[TEST_CLOCK_PIN_BIT] ==
		$past(value_ff[TEST_CLOCK_PIN_BIT]))
		else $error("enabled test clock pin not driven from value");

	test_mode_drive_a: assert property (
		(enable_ff[TEST_MODE_PIN_BIT] && !scan_active_in) |=>
		!pin_oe_n_out[TEST_MODE_PIN_BIT] &&
		pin_out[TEST_MODE_PIN_BIT] ==
		$past(value_ff[TEST_MODE_PIN_BIT]))
		else $error("enabled test mode pin not driven from value");

	data_in_drive_a: assert property (
		(enable_ff[TEST_DATA_IN_PIN_BIT] && !scan_active_in) |=>
		!pin_oe_n_out[TEST_DATA_IN_PIN_BIT] &&
		pin_out[TEST_DATA_IN_PIN_BIT] ==
		$past(value_ff[TEST_DATA_IN_PIN_BIT]))
		else $error("enabled test data in pin not driven from value");

	data_out_drive_a: assert property (
		(enable_ff[TEST_DATA_OUT_PIN_BIT] && !scan_active_in) |=>
		!pin_oe_n_out[TEST_DATA_OUT_PIN_BIT] &&
		pin_out[TEST_DATA_OUT_PIN_BIT] ==
		$past(value_ff[TEST_DATA_OUT_PIN_BIT]))
		else $error("enabled test data out pin not driven from value");

	scan_level_a: assert property (
		scan_active_in |=>
		pin_out[TEST_CLOCK_PIN_BIT:TEST_DATA_OUT_PIN_BIT] ==
		$past(func_level_in[TEST_CLOCK_PIN_BIT:TEST_DATA_OUT_PIN_BIT]))
		else $error("test port level not kept under scan");

	enable_readback_a: assert property (
		(req_in.rd && req_in.addr == PIN_OUTPUT_ENABLE_OFS) |=>
		rdata_out == $past(enable_ff))
		else $error("enable register read back wrong");

	value_readback_a: assert property (
		(req_in.rd && req_in.addr == PIN_OUTPUT_VALUE_OFS) |=>
		rdata_out == $past(value_ff))
		else $error("value register read back wrong");

	value_write_a: assert property (
		wr_value |=> value_ff == $past(req_in.wdata))
		else $error("value register write lost");

	input_write_ignored_a: assert property (
		(req_in.wr && req_in.addr == PIN_INPUT_VALUE_OFS) |=>
		enable_ff == $past(enable_ff) && value_ff == $past(value_ff))
		else $error("write to input register changed a register");

	signal_pin_keep_a: assert property (
		!enable_ff[SIGNAL_INPUT_PIN_BIT] |=>
		pin_oe_n_out[SIGNAL_INPUT_PIN_BIT] ==
		!$past(func_drive_in[SIGNAL_INPUT_PIN_BIT]) &&
		pin_out[SIGNAL_INPUT_PIN_BIT] ==
		$past(func_level_in[SIGNAL_INPUT_PIN_BIT]))
		else $error("disabled signal pin left its dedicated function");

endmodule : pin_reuse_gpio

`default_nettype wire

// ===== rtl/pin_reuse_gpio_pkg.sv
// constants and carrier types of the pin reuse general i/o block
package pin_reuse_gpio_pkg;

	// ------------------------------------------------------------
	// widths
	// ------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int PIN_N  = 8;
	localparam int SEL_W  = 4;

	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [ADDR_W-1:0] PIN_OUTPUT_ENABLE_OFS = 8'h44;
	localparam logic [ADDR_W-1:0] PIN_OUTPUT_VALUE_OFS  = 8'h45;
	localparam logic [ADDR_W-1:0] PIN_INPUT_VALUE_OFS   = 8'h46;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [DATA_W-1:0] PIN_OUTPUT_ENABLE_RST = 8'h00;
	localparam logic [DATA_W-1:0] PIN_OUTPUT_VALUE_RST  = 8'h00;
	localparam logic [DATA_W-1:0] PIN_INPUT_VALUE_RST   = 8'h00;
	localparam logic [DATA_W-1:0] READ_DATA_RST         = 8'h00;
	localparam logic [DATA_W-1:0] UNMAPPED_READ_VALUE   = 8'h00;

	// ------------------------------------------------------------
	// bit positions, shared by all three registers
	// ------------------------------------------------------------
	localparam int SIGNAL_INPUT_PIN_BIT       = 7;
	localparam int CLOCK_OUTPUT_PIN_BIT       = 6;
	localparam int INTERFACE_SELECT_PIN_B_BIT = 5;
	localparam int INTERFACE_SELECT_PIN_A_BIT = 4;
	localparam int TEST_CLOCK_PIN_BIT         = 3;
	localparam int TEST_MODE_PIN_BIT          = 2;
	localparam int TEST_DATA_IN_PIN_BIT       = 1;
	localparam int TEST_DATA_OUT_PIN_BIT      = 0;

	// the four test-port pins that boundary scan keeps for itself
	localparam logic [PIN_N-1:0] TEST_PORT_MASK = 8'h0f;

	// clock pin source code that leaves the pin free for i/o
	localparam logic [SEL_W-1:0] CLOCK_SEL_IO = 4'h0;

	// ------------------------------------------------------------
	// carrier types
	// ------------------------------------------------------------
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} reg_req_t;

endpackage : pin_reuse_gpio_pkg

// ===== verification/testbench.sv
// self-checking bench for the pin reuse general i/o block
`timescale 1ns/1ps
`default_nettype none

module testbench;
	import pin_reuse_gpio_pkg::*;

	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic              clk_in = 1'b0;
	logic              nrst_in = 1'b0;
	reg_req_t          req_in = '0;
	logic [DATA_W-1:0] rdata_out;
	logic              scan_active_in = 1'b0;
	logic [SEL_W-1:0]  sel = 4'h0;
	logic              clk_lvl = 1'b0;
	logic [PIN_N-1:0]  func_drive_in = 8'h00;
	logic [PIN_N-1:0]  func_level_in = 8'h00;
	logic [PIN_N-1:0]  func_seen_out;
	logic [PIN_N-1:0]  pin_in = 8'h00;
	logic [PIN_N-1:0]  pin_out;
	logic [PIN_N-1:0]  pin_oe_n_out;
	int                err_count = 0;
	int                samples_checked = 0;

	always #5 clk_in = ~clk_in;

	pin_reuse_gpio pin_reuse_gpio_inst (
		.clk_in                     (clk_in),
		.nrst_in                    (nrst_in),
		.req_in                     (req_in),
		.rdata_out                  (rdata_out),
		.scan_active_in             (scan_active_in),
		.clock_pin_source_select_in (sel),
		.clock_source_level_in      (clk_lvl),
		.func_drive_in              (func_drive_in),
		.func_level_in              (func_level_in),
		.func_seen_out              (func_seen_out),
		.pin_in                     (pin_in),
		.pin_out                    (pin_out),
		.pin_oe_n_out               (pin_oe_n_out)
	);

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		req_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk_in);
		req_in <= '0;
	endtask : wr

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_in);
		req_in <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk_in);
		req_in <= '0;
		#1;
		check(rdata_out, e);
	endtask : rd

	// pads are registered behind the register, so allow two edges
	task automatic settle;
		repeat (2) @(posedge clk_in);
		#1;
	endtask : settle

	task automatic wrap_up;
		$display("mismatches %0d, checks %0d", err_count, samples_checked);
		if (err_count == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : wrap_up

	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		repeat (5) @(posedge clk_in);
		check(pin_oe_n_out, 8'hff);
		nrst_in <= 1'b1;
		rd(PIN_OUTPUT_ENABLE_OFS, PIN_OUTPUT_ENABLE_RST);
		rd(PIN_OUTPUT_VALUE_OFS, PIN_OUTPUT_VALUE_RST);
		rd(PIN_INPUT_VALUE_OFS, 8'h00);
		wr(PIN_OUTPUT_VALUE_OFS, 8'ha5);
		rd(PIN_OUTPUT_VALUE_OFS, 8'ha5);
		for (int i = 0; i < 8; i++) begin
			wr(PIN_OUTPUT_ENABLE_OFS, 8'h01 << i);
			settle;
			check(pin_oe_n_out, ~(8'h01 << i));
		end
		wr(PIN_OUTPUT_ENABLE_OFS, 8'hff);
		rd(PIN_OUTPUT_ENABLE_OFS, 8'hff);
		settle;
		check(pin_oe_n_out, 8'h00);
		check(pin_out, 8'ha5);
		wr(PIN_OUTPUT_VALUE_OFS, 8'h5a);
		settle;
		check(pin_out, 8'h5a);
		wr(PIN_OUTPUT_VALUE_OFS, 8'ha5);
		// boundary scan keeps the four test pins
		@(posedge clk_in);
		scan_active_in <= 1'b1;
		settle;
		check(pin_oe_n_out, 8'h0f);
		@(posedge clk_in);
		func_drive_in <= 8'hff;
		func_level_in <= 8'h0c;
		settle;
		check(pin_out, 8'hac);
		check(pin_oe_n_out, 8'h00);
		@(posedge clk_in);
		scan_active_in <= 1'b0;
		func_drive_in <= 8'hbf;
		func_level_in <= 8'h3c;
		wr(PIN_OUTPUT_ENABLE_OFS, 8'h00);
		settle;
		check(pin_oe_n_out, 8'h40);
		check(pin_out & 8'hbf, 8'h3c);
		@(posedge clk_in);
		sel <= 4'h3;
		clk_lvl <= 1'b1;
		settle;
		check(pin_out, 8'h7c);
		wr(PIN_OUTPUT_ENABLE_OFS, 8'h40);
		settle;
		check(pin_out, 8'h3c);
		@(posedge clk_in);
		clk_lvl <= 1'b0;
		wr(PIN_OUTPUT_VALUE_OFS, 8'h40);
		settle;
		check(pin_out, 8'h7c);
		check(pin_oe_n_out, 8'h00);
		// input register and refused accesses
		@(posedge clk_in);
		pin_in <= 8'h5a;
		settle;
		check(func_seen_out, 8'h5a);
		rd(PIN_INPUT_VALUE_OFS, 8'h5a);
		wr(PIN_INPUT_VALUE_OFS, 8'hff);
		rd(PIN_INPUT_VALUE_OFS, 8'h5a);
		rd(8'h47, UNMAPPED_READ_VALUE);
		wr(8'h47, 8'hff);
		rd(PIN_OUTPUT_ENABLE_OFS, 8'h40);
		@(posedge clk_in);
		#1;
		check(rdata_out, 8'h00);
		// reset in mid-run releases every pad
		@(posedge clk_in);
		nrst_in <= 1'b0;
		@(posedge clk_in);
		#1;
		check(pin_oe_n_out, 8'hff);
		@(posedge clk_in);
		nrst_in <= 1'b1;
		rd(PIN_OUTPUT_ENABLE_OFS, PIN_OUTPUT_ENABLE_RST);
		wrap_up;
	end

	// the tests need about 100 cycles; this limit is far beyond that
	initial begin
		#50000;
		err_count++;
		wrap_up;
	end

endmodule : testbench

`default_nettype wire
